// file: rtl/ecd_error_detect.sv
// Configuration memory CRC checker with error location search and fault injection
// Functional notes
// - Configuration checks each frame's CRC; stops on mismatch or on completion.
// - Byte engine yields 16 check bits per frame, kept in a per-frame chain.
// - User mode rescans all frames repeatedly until restart input goes low.
// - Scanning starts on user-mode entry only if detection option was enabled.
// - Zero frame signature means no error and clears the soft-error flag.
// - Non-zero signature starts the search for the erroneous bit location.
// - Soft-error flag goes high whenever a frame check finds bit errors.
// - Any one, two or three flipped bits within a frame are detected.
// - Single and double-adjacent errors are located; others reported as unlocated.
// - Checking continues with following frames whether or not an error was found.
// - Generator is the 16-bit ANSI CRC polynomial.
// - Only configuration cells are checked; flag holds last checked frame's status.
// - Instruction code 00 0001 0101 selects the 21-bit fault injection register.
// - Fault injection takes effect only in user mode.
// - Loading the injection register flips chosen bits and enters error test mode.
// - Injection targets the first frame only; error information readable anytime.
// - Type bits 20:19 select 01 single byte, 10 double-adjacent bytes, 00 none.
// - Type bits both set decode as no injection.
// - Bits 18:8 give the byte position within the first frame.
// - Bits 7:0 give the byte pattern of bits to flip.
`default_nettype none
module ecd_error_detect #(
    parameter int NUM_FRAMES = 4,
    parameter int FRAME_BYTES = 16
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    input wire logic config_restart_n,
    input wire logic cfgValid,
    input wire logic [7:0] cfgByte,
    input wire logic cfgDetectEnable,
    output logic cfgReady,
    output logic cfgCrcFail,
    output logic userMode,
    input wire logic [9:0] jtagIr,
    input wire logic jtagShift,
    input wire logic jtagUpdate,
    input wire logic jtagTdi,
    output logic jtagTdo,
    input wire logic coreMsgShift,
    output logic coreMsgOut,
    output logic msgValid,
    output logic crcError,
    output logic errTestMode,
    output logic [15:0] frameSignature
);
    import ecd_pkg::*;

    localparam int FW = (NUM_FRAMES > 1) ? $clog2(NUM_FRAMES) : 1;
    localparam int BW = $clog2(FRAME_BYTES + 2);
    localparam int CELLS = NUM_FRAMES * FRAME_BYTES;
    localparam logic [15:0] FRAME_BITS = 16'(FRAME_BYTES * 8 + 16);
    localparam logic [BW-1:0] LAST_DATA = BW'(FRAME_BYTES - 1);
    localparam logic [BW-1:0] CRC_HI_IDX = BW'(FRAME_BYTES);
    localparam logic [BW-1:0] CRC_LO_IDX = BW'(FRAME_BYTES + 1);
    localparam logic [FW-1:0] LAST_FRAME = FW'(NUM_FRAMES - 1);

    ecd_state_t state_reg, state_next;
    logic [FW-1:0] frame_reg, frame_next;
    logic [BW-1:0] byte_reg, byte_next;
    logic [7:0] cells_reg [CELLS];
    logic [7:0] cells_next [CELLS];
    logic [15:0] chain_reg [NUM_FRAMES];
    logic [15:0] chain_next [NUM_FRAMES];
    logic [15:0] sig_reg, sig_next;
    logic [15:0] searchR_reg, searchR_next;
    logic [15:0] searchD_reg, searchD_next;
    logic [INJ_W-1:0] inj_reg, inj_next;
    logic [MSG_W-1:0] msg_reg, msg_next;
    logic msgValid_reg, msgValid_next;
    logic crcError_reg, crcError_next;
    logic errTest_reg, errTest_next;
    logic cfgFail_reg, cfgFail_next;

    logic engClr;
    logic engFeed;
    logic [7:0] engByte;
    logic [15:0] engCrc;

    logic [1:0] injType;
    logic [10:0] injLoc;
    logic [7:0] injPat;
    logic [15:0] dblSyn;

    function automatic int cellIdx(input logic [FW-1:0] f, input logic [BW-1:0] b);
        cellIdx = int'(f) * FRAME_BYTES + int'(b);
    endfunction : cellIdx

    function automatic logic [MSG_W-1:0] packMsg(input logic [FW-1:0] f, input logic [15:0] ofs,
                                                input logic [1:0] kind);
        packMsg = {MSG_FRAME_W'(f), ofs, kind};
    endfunction : packMsg

    ecd_crc_engine u_engine (
        .clk(clk),
        .nrst(nrst),
        .ce(ce),
        .clr(engClr),
        .feed(engFeed),
        .dataIn(engByte),
        .crc(engCrc)
    );

    assign injType = inj_reg[INJ_TYPE_HI:INJ_TYPE_LO];
    assign injLoc = inj_reg[INJ_LOC_HI:INJ_LOC_LO];
    assign injPat = inj_reg[INJ_PAT_HI:INJ_PAT_LO];
    assign dblSyn = crc16MulX(searchR_reg) ^ searchR_reg;

    always_comb begin
        state_next = state_reg;
        frame_next = frame_reg;
        byte_next = byte_reg;
        cells_next = cells_reg;
        chain_next = chain_reg;
        sig_next = sig_reg;
        searchR_next = searchR_reg;
        searchD_next = searchD_reg;
        inj_next = inj_reg;
        msg_next = msg_reg;
        msgValid_next = msgValid_reg;
        crcError_next = crcError_reg;
        errTest_next = errTest_reg;
        cfgFail_next = cfgFail_reg;
        engClr = 1'b0;
        engFeed = 1'b0;
        engByte = 8'h00;

        // Shifting readouts first, so a message load below wins over the clear
        if (jtagShift && jtagIr == INJECT_INSTR) begin
            inj_next = {jtagTdi, inj_reg[INJ_W-1:1]};
        end
        if (jtagShift && jtagIr == SHIFT_ERR_INSTR) begin
            msg_next = {1'b0, msg_reg[MSG_W-1:1]};
            msgValid_next = 1'b0;
        end else if (coreMsgShift) begin
            msg_next = {1'b0, msg_reg[MSG_W-1:1]};
            msgValid_next = 1'b0;
        end

        case (state_reg)
            ST_CONFIG: begin
                if (cfgValid) begin
                    engFeed = 1'b1;
                    engByte = cfgByte;
                    if (byte_reg <= LAST_DATA) begin
                        cells_next[cellIdx(frame_reg, byte_reg)] = cfgByte;
                    end else if (byte_reg == CRC_HI_IDX) begin
                        chain_next[frame_reg][15:8] = cfgByte;
                    end else begin
                        chain_next[frame_reg][7:0] = cfgByte;
                    end
                    if (byte_reg == CRC_LO_IDX) begin
                        byte_next = '0;
                        state_next = ST_CFG_CHECK;
                    end else begin
                        byte_next = byte_reg + BW'(1);
                    end
                end
            end
            ST_CFG_CHECK: begin
                engClr = 1'b1;
                if (engCrc != 16'h0000) begin
                    cfgFail_next = 1'b1;
                    state_next = ST_CFG_FAIL;
                end else if (frame_reg == LAST_FRAME) begin
                    frame_next = '0;
                    state_next = cfgDetectEnable ? ST_SCAN : ST_USER_IDLE;
                end else begin
                    frame_next = frame_reg + FW'(1);
                    state_next = ST_CONFIG;
                end
            end
            ST_SCAN: begin
                // Memory blocks and I/O flops are not part of this walk
                engFeed = 1'b1;
                if (byte_reg <= LAST_DATA) begin
                    engByte = cells_reg[cellIdx(frame_reg, byte_reg)];
                end else if (byte_reg == CRC_HI_IDX) begin
                    engByte = chain_reg[frame_reg][15:8];
                end else begin
                    engByte = chain_reg[frame_reg][7:0];
                end
                if (byte_reg == CRC_LO_IDX) begin
                    byte_next = '0;
                    state_next = ST_EVAL;
                end else begin
                    byte_next = byte_reg + BW'(1);
                end
            end
            ST_EVAL: begin
                // Residue over data plus stored check bits is zero for a clean frame
                engClr = 1'b1;
                sig_next = engCrc;
                crcError_next = (engCrc != 16'h0000);
                if (engCrc != 16'h0000) begin
                    // Lone error bit at distance 0 leaves x^16 mod generator
                    searchR_next = CRC_POLY;
                    searchD_next = 16'h0000;
                    state_next = ST_SEARCH;
                end else begin
                    frame_next = (frame_reg == LAST_FRAME) ? '0 : frame_reg + FW'(1);
                    state_next = ST_SCAN;
                end
            end
            ST_SEARCH: begin
                // One syndrome step per cycle; search time grows with frame length
                if (sig_reg == searchR_reg) begin
                    msg_next = packMsg(frame_reg, FRAME_BITS - 16'h0001 - searchD_reg, MSG_SINGLE);
                    msgValid_next = 1'b1;
                    state_next = ST_SCAN;
                end else if (sig_reg == dblSyn && searchD_reg < FRAME_BITS - 16'h0001) begin
                    msg_next = packMsg(frame_reg, FRAME_BITS - 16'h0002 - searchD_reg, MSG_DOUBLE);
                    msgValid_next = 1'b1;
                    state_next = ST_SCAN;
                end else if (searchD_reg == FRAME_BITS - 16'h0001) begin
                    msg_next = packMsg(frame_reg, 16'h0000, MSG_UNLOCATED);
                    msgValid_next = 1'b1;
                    state_next = ST_SCAN;
                end else begin
                    searchD_next = searchD_reg + 16'h0001;
                    searchR_next = crc16MulX(searchR_reg);
                end
                if (state_next == ST_SCAN) begin
                    frame_next = (frame_reg == LAST_FRAME) ? '0 : frame_reg + FW'(1);
                end
            end
            ST_CFG_FAIL, ST_USER_IDLE: begin
                state_next = state_reg;
            end
            default: begin
                state_next = ST_CONFIG;
            end
        endcase

        // Injection acts on frame 0 storage; the scan sees it at its next read of the changed bytes, which may fall in the current pass
        if (jtagUpdate && jtagIr == INJECT_INSTR && userMode) begin
            if (injType == INJ_SINGLE || injType == INJ_DOUBLE) begin
                if (int'(injLoc) < FRAME_BYTES) begin
                    cells_next[int'(injLoc)] = cells_reg[int'(injLoc)] ^ injPat;
                end
                if (injType == INJ_DOUBLE && int'(injLoc) + 1 < FRAME_BYTES) begin
                    cells_next[int'(injLoc) + 1] = cells_reg[int'(injLoc) + 1] ^ injPat;
                end
                errTest_next = 1'b1;
            end
        end

        // Restart abandons progress and flags; stored cells, check bits, signature, message bits and injection data are kept
        if (!config_restart_n) begin
            state_next = ST_CONFIG;
            frame_next = '0;
            byte_next = '0;
            engClr = 1'b1;
            engFeed = 1'b0;
            crcError_next = 1'b0;
            // Signature kept, so a non-zero value can stand beside the cleared flag
            sig_next = sig_reg;
            errTest_next = 1'b0;
            cfgFail_next = 1'b0;
            msgValid_next = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_reg <= ST_CONFIG;
            frame_reg <= '0;
            byte_reg <= '0;
            for (int i = 0; i < CELLS; i++) begin
                cells_reg[i] <= 8'h00;
            end
            for (int i = 0; i < NUM_FRAMES; i++) begin
                chain_reg[i] <= CRC_INIT;
            end
            sig_reg <= CRC_INIT;
            searchR_reg <= 16'h0001;
            searchD_reg <= 16'h0000;
            inj_reg <= INJ_RESET;
            msg_reg <= MSG_RESET;
            msgValid_reg <= 1'b0;
            crcError_reg <= 1'b0;
            errTest_reg <= 1'b0;
            cfgFail_reg <= 1'b0;
        end else if (ce) begin
            state_reg <= state_next;
            frame_reg <= frame_next;
            byte_reg <= byte_next;
            cells_reg <= cells_next;
            chain_reg <= chain_next;
            sig_reg <= sig_next;
            searchR_reg <= searchR_next;
            searchD_reg <= searchD_next;
            inj_reg <= inj_next;
            msg_reg <= msg_next;
            msgValid_reg <= msgValid_next;
            crcError_reg <= crcError_next;
            errTest_reg <= errTest_next;
            cfgFail_reg <= cfgFail_next;
        end
    end

    assign cfgReady = (state_reg == ST_CONFIG) && config_restart_n;
    assign cfgCrcFail = cfgFail_reg;
    assign userMode = (state_reg == ST_USER_IDLE) || (state_reg == ST_SCAN) || (state_reg == ST_EVAL)
                      || (state_reg == ST_SEARCH);
    assign jtagTdo = (jtagIr == INJECT_INSTR) ? inj_reg[0] : msg_reg[0];
    assign coreMsgOut = msg_reg[0];
    assign msgValid = msgValid_reg;
    assign crcError = crcError_reg;
    assign errTestMode = errTest_reg;
    assign frameSignature = sig_reg;
endmodule : ecd_error_detect
`default_nettype wire

// file: pkg/ecd_pkg.sv
// Shared constants, types and CRC arithmetic for the configuration error detector
`default_nettype none
package ecd_pkg;
    // CRC generator x^16 + x^15 + x^2 + 1, MSB-first, zero initial value
    localparam logic [15:0] CRC_POLY = 16'h8005;
    localparam logic [15:0] CRC_INIT = 16'h0000;

    // Instruction codes (10-bit instruction register)
    localparam logic [9:0] INJECT_INSTR = 10'h015;
    localparam logic [9:0] SHIFT_ERR_INSTR = 10'h016;

    // Fault injection control register layout
    localparam int INJ_W = 21;
    localparam int INJ_TYPE_HI = 20;
    localparam int INJ_TYPE_LO = 19;
    localparam int INJ_LOC_HI = 18;
    localparam int INJ_LOC_LO = 8;
    localparam int INJ_PAT_HI = 7;
    localparam int INJ_PAT_LO = 0;
    localparam logic [20:0] INJ_RESET = 21'h0_0000;
    localparam logic [1:0] INJ_NONE = 2'h0;
    localparam logic [1:0] INJ_SINGLE = 2'h1;
    localparam logic [1:0] INJ_DOUBLE = 2'h2;

    // Error message register layout: {frame, bit offset, type}
    localparam int MSG_TYPE_W = 2;
    localparam int MSG_OFS_W = 16;
    localparam int MSG_FRAME_W = 8;
    localparam int MSG_W = MSG_FRAME_W + MSG_OFS_W + MSG_TYPE_W;
    localparam logic [1:0] MSG_SINGLE = 2'h1;
    localparam logic [1:0] MSG_DOUBLE = 2'h2;
    localparam logic [1:0] MSG_UNLOCATED = 2'h3;
    localparam logic [25:0] MSG_RESET = 26'h000_0000;

    typedef enum logic [2:0] {
        ST_CONFIG, ST_CFG_CHECK, ST_CFG_FAIL, ST_USER_IDLE, ST_SCAN, ST_EVAL, ST_SEARCH
    } ecd_state_t;

    // Multiply the remainder by x modulo the generator
    function automatic logic [15:0] crc16MulX(input logic [15:0] r);
        crc16MulX = {r[14:0], 1'b0} ^ (r[15] ? CRC_POLY : 16'h0000);
    endfunction : crc16MulX

    // Fold one byte into the running CRC, most significant bit first
    function automatic logic [15:0] crc16Byte(input logic [15:0] crc, input logic [7:0] data);
        logic [15:0] c;
        c = crc;
        for (int i = 7; i >= 0; i--) begin
            c = crc16MulX(c) ^ ((c[15] ^ data[i]) != c[15] ? CRC_POLY : 16'h0000);
        end
        crc16Byte = c;
    endfunction : crc16Byte
endpackage : ecd_pkg
`default_nettype wire

// file: rtl/ecd_crc_engine.sv
// Byte-serial CRC-16 accumulator shared by configuration and user-mode checking
`default_nettype none
module ecd_crc_engine (
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    input wire logic clr,
    input wire logic feed,
    input wire logic [7:0] dataIn,
    output logic [15:0] crc
);
    import ecd_pkg::*;

    logic [15:0] crc_reg;
    logic [15:0] crc_next;

    always_comb begin
        crc_next = crc_reg;
        if (clr) begin
            crc_next = CRC_INIT;
        end else if (feed) begin
            crc_next = crc16Byte(crc_reg, dataIn);
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            crc_reg <= CRC_INIT;
        end else if (ce) begin
            crc_reg <= crc_next;
        end
    end

    assign crc = crc_reg;
endmodule : ecd_crc_engine
`default_nettype wire

// file: testbench/ecd_error_detect_checker.sv
// Port-level assertions for the configuration error detector
`default_nettype none
module ecd_error_detect_checker (
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    input wire logic config_restart_n,
    input wire logic cfgReady,
    input wire logic cfgCrcFail,
    input wire logic userMode,
    input wire logic [9:0] jtagIr,
    input wire logic jtagUpdate,
    input wire logic jtagTdo,
    input wire logic coreMsgOut,
    input wire logic msgValid,
    input wire logic crcError,
    input wire logic errTestMode,
    input wire logic [15:0] frameSignature
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    sequence restartSeq;
        !config_restart_n && ce;
    endsequence
    sequence injectSeq;
        ce && jtagUpdate && jtagIr == 10'h015 && !userMode && !errTestMode;
    endsequence
    chk_user_refuses: assert property (userMode |-> !cfgReady) else $error("ready in user mode");
    chk_fail_sticky: assert property (cfgCrcFail && config_restart_n && ce |=> cfgCrcFail)
        else $error("crc fail dropped");
    chk_fail_stops: assert property (cfgCrcFail |-> !cfgReady && !userMode) else $error("load went on");
    chk_restart_clears: assert property (restartSeq |=> !crcError && !errTestMode && !cfgCrcFail)
        else $error("restart left flags");
    chk_restart_mode: assert property (restartSeq |=> !userMode [*2]) else $error("user mode kept");
    chk_sig_flag: assert property ($changed(frameSignature) |-> crcError == (frameSignature != 16'h0000))
        else $error("flag disagrees with signature");
    chk_inject_cause: assert property ($rose(errTestMode) |->
        $past(ce) && $past(jtagUpdate) && $past(jtagIr) == 10'h015 && $past(userMode))
        else $error("test mode without injection");
    chk_inject_user: assert property (injectSeq |=> !errTestMode) else $error("inject outside user mode");
    chk_info_read: assert property (jtagIr != 10'h015 |-> jtagTdo == coreMsgOut) else $error("tdo mux");
    chk_msg_user: assert property (!userMode |-> !msgValid) else $error("message outside user mode");
endmodule : ecd_error_detect_checker
bind ecd_error_detect ecd_error_detect_checker i_chk (.clk(clk), .nrst(nrst), .ce(ce),
    .config_restart_n(config_restart_n), .cfgReady(cfgReady), .cfgCrcFail(cfgCrcFail), .userMode(userMode),
    .jtagIr(jtagIr), .jtagUpdate(jtagUpdate), .jtagTdo(jtagTdo), .coreMsgOut(coreMsgOut),
    .msgValid(msgValid), .crcError(crcError), .errTestMode(errTestMode), .frameSignature(frameSignature));
`default_nettype wire

// file: testbench/ecd_host_model.sv
// Behavioural bitstream source and test-port host facing the detector
`default_nettype none
module ecd_host_model (
    input wire logic clk,
    input wire logic cfgReady,
    input wire logic jtagTdo,
    input wire logic coreMsgOut,
    output logic cfgValid,
    output logic [7:0] cfgByte,
    output logic [9:0] jtagIr,
    output logic jtagShift,
    output logic jtagUpdate,
    output logic jtagTdi,
    output logic coreMsgShift
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        cfgValid = 1'b0;
        cfgByte = 8'h00;
        jtagIr = 10'h000;
        jtagShift = 1'b0;
        jtagUpdate = 1'b0;
        jtagTdi = 1'b0;
        coreMsgShift = 1'b0;
    end
    // Byte held until an edge sees ready
    task automatic sendByte(input logic [7:0] b, output logic ok);
        int n;
        @(negedge clk);
        cfgValid = 1'b1;
        cfgByte = b;
        n = 0;
        while (cfgReady !== 1'b1 && n < 20) begin
            @(negedge clk);
            n++;
        end
        ok = n < 20;
        @(posedge clk);
    endtask : sendByte
    // Released byte lane shows the inverse, not a stale copy
    task automatic cfgIdle;
        @(negedge clk);
        cfgValid = 1'b0;
        cfgByte = ~cfgByte;
    endtask : cfgIdle
    task automatic inject(input logic [20:0] v);
        @(negedge clk);
        jtagIr = 10'h015;
        jtagShift = 1'b1;
        for (int i = 0; i < 21; i++) begin
            jtagTdi = v[i];
            @(negedge clk);
        end
        jtagShift = 1'b0;
        jtagTdi = ~jtagTdi;
        jtagUpdate = 1'b1;
        @(negedge clk);
        jtagUpdate = 1'b0;
    endtask : inject
    // Read whole message before the next one lands
    task automatic readMsg(input logic viaJtag, output logic [25:0] m);
        @(negedge clk);
        jtagIr = viaJtag ? 10'h016 : 10'h000;
        for (int i = 0; i < 26; i++) begin
            #1;
            m[i] = viaJtag ? jtagTdo : coreMsgOut;
            jtagShift = viaJtag;
            coreMsgShift = !viaJtag;
            @(negedge clk);
        end
        jtagShift = 1'b0;
        coreMsgShift = 1'b0;
    endtask : readMsg
endmodule : ecd_host_model
`default_nettype wire

// file: testbench/tb.sv
// Self-checking bench for the configuration memory error detector
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import ecd_pkg::*;
    localparam int NF = 3;
    localparam int FB = 4;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic config_restart_n = 1'b1;
    logic cfgDetectEnable = 1'b0;
    logic ce = 1'b1;
    logic cfgValid, cfgReady, cfgCrcFail, userMode, jtagShift, jtagUpdate, jtagTdi, jtagTdo;
    logic coreMsgShift, coreMsgOut, msgValid, crcError, errTestMode;
    logic [7:0] cfgByte;
    logic [9:0] jtagIr;
    logic [15:0] frameSignature;
    int err_count = 0;
    int n_checks = 0;
    int seed = 32'h0000_1cfc;
    always #2.5 clk = ~clk;
    ecd_error_detect #(.NUM_FRAMES(NF), .FRAME_BYTES(FB)) i_ecd_error_detect (.clk(clk), .nrst(nrst), .ce(ce),
        .config_restart_n(config_restart_n), .cfgValid(cfgValid), .cfgByte(cfgByte),
        .cfgDetectEnable(cfgDetectEnable), .cfgReady(cfgReady), .cfgCrcFail(cfgCrcFail), .userMode(userMode),
        .jtagIr(jtagIr), .jtagShift(jtagShift), .jtagUpdate(jtagUpdate), .jtagTdi(jtagTdi), .jtagTdo(jtagTdo),
        .coreMsgShift(coreMsgShift), .coreMsgOut(coreMsgOut), .msgValid(msgValid), .crcError(crcError),
        .errTestMode(errTestMode), .frameSignature(frameSignature));
    ecd_host_model i_ecd_host_model (.clk(clk), .cfgReady(cfgReady), .jtagTdo(jtagTdo), .coreMsgOut(coreMsgOut),
        .cfgValid(cfgValid), .cfgByte(cfgByte), .jtagIr(jtagIr), .jtagShift(jtagShift), .jtagUpdate(jtagUpdate),
        .jtagTdi(jtagTdi), .coreMsgShift(coreMsgShift));
    function automatic logic [15:0] crcStep(input logic [15:0] c, input logic [7:0] b);
        logic fb;
        for (int i = 7; i >= 0; i--) begin
            fb = c[15] ^ b[i];
            c = {c[14:0], 1'b0} ^ (fb ? 16'h8005 : 16'h0000);
        end
        return c;
    endfunction : crcStep
    // Data MSB of byte 0 is offset 0
    function automatic logic [25:0] expMsg(input int loc, input int bi);
        return {8'h00, 16'(loc * 8 + 7 - bi), MSG_SINGLE};
    endfunction : expMsg
    // Residue of a lone flipped bit; the CRC is linear with zero start
    function automatic logic [15:0] expSig(input int loc, input int bi);
        logic [15:0] c;
        c = 16'h0000;
        for (int k = 0; k < FB + 2; k++) begin
            c = crcStep(c, k == loc ? 8'(1 << bi) : 8'h00);
        end
        return c;
    endfunction : expSig
    task automatic cmpBit(input logic got, input logic exp, input string what);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: %s is %b", $time, what, got);
        end
    endtask : cmpBit
    task automatic cmpMsg(input logic [25:0] got, input logic [25:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: message %h, wanted %h", $time, got, exp);
        end
    endtask : cmpMsg
    task automatic test_done;
        $display("checks %0d, mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : test_done
    task automatic waitFor(input logic onMsg, input logic v);
        int n;
        n = 0;
        while (((onMsg ? msgValid : crcError) !== v) && n < 2000) begin
            @(negedge clk);
            n++;
        end
        if (n >= 2000) begin
            err_count++;
            $display("unexpected at %0t: wait ran out", $time);
            test_done();
        end
    endtask : waitFor
    task automatic configure(input logic detect, input int badFrame);
        logic [7:0] b;
        logic [15:0] c;
        logic ok;
        logic allOk;
        allOk = 1'b1;
        @(negedge clk);
        config_restart_n = 1'b0;
        @(negedge clk);
        config_restart_n = 1'b1;
        cfgDetectEnable = detect;
        for (int f = 0; f < NF && f <= badFrame; f++) begin
            c = 16'h0000;
            for (int k = 0; k < FB + 2; k++) begin
                b = k < FB ? 8'($random(seed)) : (k == FB ? c[15:8] : c[7:0] ^ 8'(f == badFrame));
                if (k < FB) c = crcStep(c, b);
                i_ecd_host_model.sendByte(b, ok);
                allOk &= ok;
            end
        end
        i_ecd_host_model.cfgIdle();
        repeat (3) @(negedge clk);
        cmpBit(allOk, 1'b1, "bytes taken");
        cmpBit(cfgCrcFail, badFrame < NF, "crc fail");
        cmpBit(userMode, badFrame >= NF, "user mode");
        cfgDetectEnable = ~detect;
    endtask : configure
    // A stale and a half-updated message may precede the clean one
    task automatic checkMsg(input logic viaJtag, input logic [25:0] exp);
        logic [25:0] m;
        repeat (3) begin
            waitFor(1'b1, 1'b1);
            i_ecd_host_model.readMsg(viaJtag, m);
        end
        cmpMsg(m, exp);
    endtask : checkMsg
    initial begin
        int loc;
        int bi;
        logic [25:0] m;
        repeat (10) @(negedge clk);
        nrst = 1'b1;
        configure(1'b1, 1);
        i_ecd_host_model.inject({INJ_SINGLE, 11'h000, 8'h01});
        cmpBit(errTestMode, 1'b0, "early test mode");
        $display("test load failure done");
        configure(1'b0, NF);
        i_ecd_host_model.inject({INJ_SINGLE, 11'h000, 8'h01});
        cmpBit(errTestMode, 1'b1, "test mode");
        repeat (NF * (FB + 3) * 4) @(negedge clk);
        cmpBit(crcError, 1'b0, "flag, detection off");
        cmpBit(msgValid, 1'b0, "message, detection off");
        $display("test detection off done");
        configure(1'b1, NF);
        repeat (NF * (FB + 3) * 2) @(negedge clk);
        cmpBit(crcError, 1'b0, "clean flag");
        cmpBit(frameSignature === 16'h0000, 1'b1, "clean signature");
        loc = $unsigned($random(seed)) % (FB - 1);
        bi = $unsigned($random(seed)) % 8;
        i_ecd_host_model.inject({2'b01, 11'(loc), 8'h01 << bi});
        checkMsg(1'b1, expMsg(loc, bi));
        waitFor(1'b1, 1'b1);
        ce = 1'b0;
        i_ecd_host_model.readMsg(1'b0, m);
        cmpBit(msgValid, 1'b1, "frozen message");
        ce = 1'b1;
        waitFor(1'b0, 1'b0);
        waitFor(1'b0, 1'b1);
        cmpBit(frameSignature === expSig(loc, bi), 1'b1, "error signature");
        for (int t = 0; t < 3; t++) begin
            i_ecd_host_model.inject({t == 0 ? 2'b11 : (t == 1 ? 2'b00 : 2'b10), 11'(loc), 8'h01 << bi});
            checkMsg(t[0], expMsg(loc + int'(t == 2), bi));
        end
        $display("test injection done");
        test_done();
    end
endmodule : tb
`default_nettype wire
